// File: hw/stpx_prescaler.sv
// Purpose: shared 10-bit prescaler and clock select for two timer/counter units
// Assumes: count pins synchronous input samples, one clock domain
// Notes: ticks are one-cycle enables; pins sampled through latch plus two registers
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module stpx_prescaler
  import stpx_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic [DATA_W-1:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [DATA_W-1:0] RDATA_OUT,
  input wire logic COUNTER0_EXT_COUNT_PIN_IN,
  input wire logic COUNTER1_EXT_COUNT_PIN_IN,
  output logic TIMER0_TICK_OUT,
  output logic TIMER1_TICK_OUT
);

  // Pick a tap for a select value; used for both timers
  function automatic logic sel_tick(input logic [2:0] cs, input stpx_taps_s tp,
                                    input logic rise, input logic fall);
    case (stpx_cs_e'(cs))
      CS_STOP: sel_tick = 1'b0;
      CS_CLK: sel_tick = 1'b1;
      CS_DIV8: sel_tick = tp.t8;
      CS_DIV64: sel_tick = tp.t64;
      CS_DIV256: sel_tick = tp.t256;
      CS_DIV1024: sel_tick = tp.t1024;
      CS_FALL: sel_tick = fall;
      CS_RISE: sel_tick = rise;
      default: sel_tick = 1'b0;
    endcase
  endfunction

  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic [2:0] cs0;
  logic [2:0] cs1;
  logic [2:0] next_cs0;
  logic [2:0] next_cs1;
  logic [DATA_W-1:0] next_rdata;
  logic div_clear;
  stpx_taps_s taps;
  logic [1:0] pin_raw;
  logic pin_latch [2];
  stpx_pin_s pin_q [2];
  stpx_pin_s next_pin [2];
  logic [1:0] rise_det;
  logic [1:0] fall_det;
  logic [1:0] tick;

  // Divider reset strobe; the bit itself is never stored so it self-clears
  assign div_clear = WR_IN && (ADDR_IN == SFIO_ADDR) && WDATA_IN[DIV_RST_BIT];

  // Free-running divider, cleared only by the reset strobe and by system reset
  always_comb begin
    if (div_clear) begin
      next_div_cnt = DIV_RESET;
    end else begin
      next_div_cnt = div_cnt + 10'h001;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN) begin
      div_cnt <= DIV_RESET;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // Tap pulses at each rollover point, one cycle each
  assign taps.t8 = ((div_cnt & MASK_8) == MASK_8);
  assign taps.t64 = ((div_cnt & MASK_64) == MASK_64);
  assign taps.t256 = ((div_cnt & MASK_256) == MASK_256);
  assign taps.t1024 = ((div_cnt & MASK_1024) == MASK_1024);

  // Register writes and read data
  always_comb begin
    next_cs0 = cs0;
    next_cs1 = cs1;
    next_rdata = 8'h00;
    if (WR_IN && ADDR_IN == CS0_ADDR) begin
      next_cs0 = WDATA_IN[2:0];
    end
    if (WR_IN && ADDR_IN == CS1_ADDR) begin
      next_cs1 = WDATA_IN[2:0];
    end
    if (RD_IN) begin
      case (ADDR_IN)
        SFIO_ADDR: next_rdata = 8'h00;
        CS0_ADDR: next_rdata = {5'h00, cs0};
        CS1_ADDR: next_rdata = {5'h00, cs1};
        STAT_ADDR: next_rdata = {6'h00, pin_q[1].sync2, pin_q[0].sync2};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN) begin
      cs0 <= CS_RESET;
      cs1 <= CS_RESET;
      RDATA_OUT <= 8'h00;
    end else begin
      cs0 <= next_cs0;
      cs1 <= next_cs1;
      RDATA_OUT <= next_rdata;
    end
  end

  assign pin_raw = {COUNTER1_EXT_COUNT_PIN_IN, COUNTER0_EXT_COUNT_PIN_IN};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      // Latch open while the clock is high, closed while low
      always_latch begin
        if (MCLK_IN) begin
          pin_latch[g] = pin_raw[g];
        end
      end

      // Synchroniser stages and edge history
      always_comb begin
        next_pin[g].sync1 = pin_latch[g];
        next_pin[g].sync2 = pin_q[g].sync1;
        next_pin[g].prev = pin_q[g].sync2;
      end

      always_ff @(posedge MCLK_IN) begin
        if (!RESET_N_IN) begin
          pin_q[g] <= '0;
        end else begin
          pin_q[g] <= next_pin[g];
        end
      end

      // Edge detect on synchronised level only
      assign rise_det[g] = pin_q[g].sync2 && !pin_q[g].prev;
      assign fall_det[g] = !pin_q[g].sync2 && pin_q[g].prev;
    end
  endgenerate

  // Tick selection per timer, one-cycle enables
  assign tick[0] = sel_tick(cs0, taps, rise_det[0], fall_det[0]);
  assign tick[1] = sel_tick(cs1, taps, rise_det[1], fall_det[1]);
  assign TIMER0_TICK_OUT = tick[0];
  assign TIMER1_TICK_OUT = tick[1];

  // Rising pin edge at select 7 ticks after two register stages
  a_rise_tick: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (cs0 == CS_RISE) && $stable(cs0) && rise_det[0] |-> TIMER0_TICK_OUT)
    else $error("rising edge did not tick timer0");

  a_fall_tick: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (cs1 == CS_FALL) && !fall_det[1] |-> !TIMER1_TICK_OUT)
    else $error("timer1 ticked without falling edge");

  a_stop_quiet: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (cs0 == CS_STOP) |-> !TIMER0_TICK_OUT)
    else $error("stopped timer0 ticked");

  a_div_free: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    !$past(div_clear) && $past(RESET_N_IN) |-> div_cnt == $past(div_cnt) + 10'h001)
    else $error("divider did not advance");

  a_div_clear: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    div_clear |=> div_cnt == DIV_RESET ##7 taps.t8)
    else $error("divider reset did not restart period");

  a_tap8_period: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    taps.t8 && !div_clear |=> !taps.t8 [*7])
    else $error("divide by 8 tap too frequent");

  a_first_tick: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (cs0 == CS_DIV64) && $changed(cs0)
      |-> ##[0:63] (TIMER0_TICK_OUT || div_clear || (cs0 != CS_DIV64)))
    else $error("first divide by 64 tick late");

  a_sfio_zero: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    RD_IN && ADDR_IN == SFIO_ADDR |=> RDATA_OUT == 8'h00)
    else $error("divider reset bit read nonzero");

  a_ext_pulse: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (cs1 == CS_RISE) && $stable(cs1) && TIMER1_TICK_OUT |=> !TIMER1_TICK_OUT)
    else $error("external tick longer than one cycle");

  // Synchroniser stages each copy the stage before them once a cycle
  a_first_stage0: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    $past(RESET_N_IN) |-> pin_q[0].sync1 == $past(pin_latch[0]))
    else $error("timer0 pin first stage missed the latch");

  a_first_stage1: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    $past(RESET_N_IN) |-> pin_q[1].sync1 == $past(pin_latch[1]))
    else $error("timer1 pin first stage missed the latch");

  a_second_stage0: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    $past(RESET_N_IN) |-> pin_q[0].sync2 == $past(pin_q[0].sync1)
      && pin_q[0].prev == $past(pin_q[0].sync2))
    else $error("timer0 pin second stage or history slipped");

  a_second_stage1: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    $past(RESET_N_IN) |-> pin_q[1].sync2 == $past(pin_q[1].sync1)
      && pin_q[1].prev == $past(pin_q[1].sync2))
    else $error("timer1 pin second stage or history slipped");

  // Edge walk steps: the new level sits in the latch while the first stage holds the old one
  sequence s_pin0_rise;
    pin_latch[0] && !pin_q[0].sync1;
  endsequence

  sequence s_pin1_fall;
    !pin_latch[1] && pin_q[1].sync1;
  endsequence

  // Two stages later the tick stands, so the counter moves on the third edge
  a_rise_latency: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    s_pin0_rise ##2 (cs0 == CS_RISE) |-> TIMER0_TICK_OUT)
    else $error("rising pin edge tick not on time");

  a_fall_latency: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    s_pin1_fall ##2 (cs1 == CS_FALL) |-> TIMER1_TICK_OUT)
    else $error("falling pin edge tick not on time");

  // A pin tick never comes earlier than the full walk allows
  a_rise_history: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    $past(RESET_N_IN, 3) && (cs0 == CS_RISE) && TIMER0_TICK_OUT
      |-> $past(pin_latch[0], 2) && !$past(pin_latch[0], 3))
    else $error("rising tick without a settled pin edge");

  a_fall_history: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    $past(RESET_N_IN, 3) && (cs0 == CS_FALL) && TIMER0_TICK_OUT
      |-> !$past(pin_latch[0], 2) && $past(pin_latch[0], 3))
    else $error("falling tick without a settled pin edge");

  // External ticks bypass the divider taps
  a_ext_direct: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (cs1 == CS_RISE) && rise_det[1] && !taps.t8 |-> TIMER1_TICK_OUT)
    else $error("external tick held back by the divider");

  // Writing zero to the divider reset bit leaves the divider counting
  a_zero_write: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    WR_IN && (ADDR_IN == SFIO_ADDR) && !WDATA_IN[DIV_RST_BIT]
      |=> div_cnt == $past(div_cnt) + 10'h001)
    else $error("zero write disturbed the divider");

  a_sel_free: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    WR_IN && (ADDR_IN != SFIO_ADDR) |=> div_cnt == $past(div_cnt) + 10'h001)
    else $error("select write disturbed the divider");

  // Each select value picks its own source
  a_clk_every: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (cs1 == CS_CLK) |-> TIMER1_TICK_OUT)
    else $error("undivided select missed a cycle");

  a_stop_quiet1: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (cs1 == CS_STOP) |-> !TIMER1_TICK_OUT)
    else $error("stopped timer1 ticked");

  a_tap8_match: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (cs1 == CS_DIV8) |-> TIMER1_TICK_OUT == (div_cnt[2:0] == 3'h7))
    else $error("divide by 8 tick off its rollover");

  a_tap64_match: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (cs0 == CS_DIV64) |-> TIMER0_TICK_OUT == (div_cnt[5:0] == 6'h3F))
    else $error("divide by 64 tick off its rollover");

  a_tap256_match: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (cs0 == CS_DIV256) |-> TIMER0_TICK_OUT == (div_cnt[7:0] == 8'hFF))
    else $error("divide by 256 tick off its rollover");

  a_tap1024_match: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (cs1 == CS_DIV1024) |-> TIMER1_TICK_OUT == (div_cnt == 10'h3FF))
    else $error("divide by 1024 tick off its rollover");

  a_tap_pulse: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (cs0 == CS_DIV8) && TIMER0_TICK_OUT && !WR_IN |=> !TIMER0_TICK_OUT)
    else $error("divided tick longer than one cycle");

  // A divider reset pulls both timers back to the start of their period
  sequence s_clear_seen;
    div_clear ##1 (div_cnt == DIV_RESET);
  endsequence

  a_clear_quiet0: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    s_clear_seen ##0 ((cs0 >= CS_DIV8) && (cs0 <= CS_DIV1024)) |-> !TIMER0_TICK_OUT)
    else $error("timer0 ticked right after divider reset");

  a_clear_quiet1: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    s_clear_seen ##0 ((cs1 >= CS_DIV8) && (cs1 <= CS_DIV1024)) |-> !TIMER1_TICK_OUT)
    else $error("timer1 ticked right after divider reset");

  // Select and status reads return live values with the upper bits zero
  a_read_sel0: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    RD_IN && (ADDR_IN == CS0_ADDR) |=> RDATA_OUT == {5'h00, $past(cs0)})
    else $error("timer0 select read wrong");

  a_read_sel1: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    RD_IN && (ADDR_IN == CS1_ADDR) |=> RDATA_OUT == {5'h00, $past(cs1)})
    else $error("timer1 select read wrong");

  a_read_status: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    RD_IN && (ADDR_IN == STAT_ADDR)
      |=> RDATA_OUT == {6'h00, $past(pin_q[1].sync2), $past(pin_q[0].sync2)})
    else $error("status read wrong");

endmodule // stpx_prescaler

// File: include/stpx_pkg.sv
// Purpose: constants and carriers for the shared timer prescaler and clock select block
// Assumes: one 100 MHz system clock, synchronous active-low reset
// Notes: registers sit on a plain address/strobe port, read data one cycle later
// Functional notes
// - The divider runs all the time, whatever either timer selects, and one divider serves both.
// - A timer started on a divided tap sees its first tick 1 to N cycles later, N being its divisor.
// - A divider reset restarts the divided period for both timers at once.
// - Each count pin is sampled once per cycle by a synchroniser whose output feeds an edge detector.
// - The synchroniser is a latch open while the clock is high followed by rising-edge registers.
// - The edge detector gives one tick per rising pin edge at select 7 and per falling edge at select 6.
// - Pin edge to counter update takes 2.5 to 3.5 system clock cycles.
// - External pin ticks go straight to the timer, never through a divider tap.
// - Writing one to the divider reset bit resets the divider and self-clears; zero does nothing; it reads zero.
// - With no source selected a timer gets no ticks.
// - Select 0 stops, 1 passes the clock, 2 to 5 divide by 8, 64, 256, 1024, 6 falling, 7 rising pin edge.
package stpx_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DIV_W = 10;
  // Register addresses
  localparam logic [ADDR_W-1:0] SFIO_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] CS0_ADDR = 4'h1;
  localparam logic [ADDR_W-1:0] CS1_ADDR = 4'h2;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 4'h3;
  // Field positions and reset values
  localparam int unsigned DIV_RST_BIT = 0;
  localparam logic [2:0] CS_RESET = 3'h0;
  localparam logic [DIV_W-1:0] DIV_RESET = 10'h000;
  // Divider tap masks: low bits all ones means that tap rolls over
  localparam logic [DIV_W-1:0] MASK_8 = 10'h007;
  localparam logic [DIV_W-1:0] MASK_64 = 10'h03F;
  localparam logic [DIV_W-1:0] MASK_256 = 10'h0FF;
  localparam logic [DIV_W-1:0] MASK_1024 = 10'h3FF;
  typedef enum logic [2:0] {
    CS_STOP = 3'h0,
    CS_CLK = 3'h1,
    CS_DIV8 = 3'h2,
    CS_DIV64 = 3'h3,
    CS_DIV256 = 3'h4,
    CS_DIV1024 = 3'h5,
    CS_FALL = 3'h6,
    CS_RISE = 3'h7
  } stpx_cs_e;
  // Divider tap pulses
  typedef struct packed {
    logic t8;
    logic t64;
    logic t256;
    logic t1024;
  } stpx_taps_s;
  // Per-pin synchroniser state
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
  } stpx_pin_s;
endpackage

// File: sim/stpx_counters_model.sv
// Purpose: far side model, two counter units plus external count pin sources
// Assumes: one system clock, ticks are one-cycle enables
// Notes: pins toggle every HALF cycles while run_in is high, else hold level
`timescale 1ns/10ps
module stpx_counters_model #(parameter int HALF = 3) (
  input wire logic clk_in,
  input wire logic tick0_in,
  input wire logic tick1_in,
  input wire logic run_in,
  output logic pin0_out = 1'b0,
  output logic pin1_out = 1'b0,
  output logic [15:0] cnt0_out = '0,
  output logic [15:0] cnt1_out = '0
);
  int ph = 0;
  // Counter units advance once per enabled clock
  always @(posedge clk_in) begin
    if (tick0_in === 1'b1) cnt0_out <= cnt0_out + 16'h0001;
    if (tick1_in === 1'b1) cnt1_out <= cnt1_out + 16'h0001;
  end
  // Pin source, each half period three clocks, well under the sampling limit
  always @(posedge clk_in) begin
    if (!run_in) begin
      ph <= 0;
    end else if (ph == HALF - 1) begin
      ph <= 0;
      pin0_out <= ~pin0_out;
      pin1_out <= ~pin1_out;
    end else begin
      ph <= ph + 1;
    end
  end
endmodule // stpx_counters_model

// File: sim/stpx_prescaler_bench.sv
// Purpose: self-checking bench for the shared prescaler and clock select
// Assumes: register port with one-cycle strobes, read data one cycle later
// Notes: internal-source tick counts measured over windows of two whole divider periods
`timescale 1ns/10ps
module stpx_prescaler_bench;
  import stpx_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic run = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic pin0, pin1, tick0, tick1;
  logic [15:0] cnt0, cnt1, base0, base1;
  logic [15:0] exp_ticks [6] = '{16'h0000, 16'h0800, 16'h0100, 16'h0020, 16'h0008, 16'h0002};
  int bad_count = 0;
  int compares = 0;
  // Free-running system clock
  always #5 mclk = ~mclk;
  stpx_prescaler stpx_prescaler_i (.MCLK_IN(mclk), .RESET_N_IN(reset_n), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
    .COUNTER0_EXT_COUNT_PIN_IN(pin0), .COUNTER1_EXT_COUNT_PIN_IN(pin1),
    .TIMER0_TICK_OUT(tick0), .TIMER1_TICK_OUT(tick1));
  stpx_counters_model stpx_counters_model_i (.clk_in(mclk), .tick0_in(tick0), .tick1_in(tick1),
    .run_in(run), .pin0_out(pin0), .pin1_out(pin1), .cnt0_out(cnt0), .cnt1_out(cnt1));
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One-cycle write strobe
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // One-cycle read strobe, data checked in the following cycle
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, e});
  endtask
  // Tick counts over n clock edges
  task automatic window(input int n, input logic [15:0] e0, input logic [15:0] e1);
    #1;
    base0 = cnt0;
    base1 = cnt1;
    repeat (n) @(posedge mclk);
    #1;
    chk(cnt0 - base0, e0);
    chk(cnt1 - base1, e1);
  endtask
  task automatic wrap_up();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    bad_count++;
    wrap_up();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    for (int a = 0; a < 5; a++) rd_chk((a == 4) ? 4'hF : 4'(a), 8'h00);
    $display("test reset values done");
    for (int cs = 0; cs < 6; cs++) begin
      wr_reg(CS0_ADDR, 8'(cs));
      wr_reg(CS1_ADDR, 8'(cs));
      window(2048, exp_ticks[cs], exp_ticks[cs]);
      rd_chk(CS0_ADDR, 8'(cs));
      rd_chk(CS1_ADDR, 8'(cs));
    end
    $display("test internal sources done");
    wr_reg(SFIO_ADDR, 8'hFE);
    wr_reg(SFIO_ADDR, 8'h01);
    window(1000, 16'h0000, 16'h0000);
    window(30, 16'h0001, 16'h0001);
    rd_chk(SFIO_ADDR, 8'h00);
    $display("test divider reset done");
    for (int m = 0; m < 2; m++) begin
      wr_reg(CS0_ADDR, m ? 8'h06 : 8'h07);
      wr_reg(CS1_ADDR, m ? 8'h07 : 8'h06);
      @(posedge mclk);
      run <= 1'b1;
      #1;
      base0 = cnt0;
      base1 = cnt1;
      repeat (63) @(posedge mclk);
      run <= 1'b0;
      #1;
      window(10, 16'h000B - (cnt0 - base0), 16'h000A - (cnt1 - base1));
      rd_chk(STAT_ADDR, m ? 8'h00 : 8'h03);
    end
    $display("test pin edges done");
    wrap_up();
  end
endmodule // stpx_prescaler_bench
